// >>> design/pmt_timer.sv
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
// Function
// R01 - Clocked only from system clock divided four
// R02 - Count increments by one per prescaled edge
// R03 - Prescaler divides by 1, 4 or 16
// R04 - Prescaler also divides by 64
// R05 - Count and period are eight bits
// R06 - Count equal period gives match output
// R07 - Match zeroes count, advances postscaler
// R08 - Postscaler ratio one to sixteen selectable
// R09 - Postscaler completion latches match flag
// R10 - Interrupt only while enable bit set
// R11 - Count and period readable and writable
// R12 - Reset: count zero, period all ones
// R13 - Count or control write clears scalers
// R14 - Every device reset clears both scalers
// R15 - Unscaled match drives PWM time base
// R16 - First instance can clock serial port
// R17 - Sleep stops counting, registers hold
// R18 - Up to three independent identical instances
// R19 - Count advances only while timer on
module pmt_timer #(
    parameter int NUM_TIMERS = pmt_pkg::PMT_NUM_DEF
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [pmt_pkg::PMT_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [pmt_pkg::PMT_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Device state
    input wire logic sleep_pin,
    // Timer outputs
    output logic [NUM_TIMERS-1:0] match_out,
    output logic spi_shift_clk,
    output logic irq
);
    import pmt_pkg::*;

    // ****************************************
    // Address decode
    // ****************************************
    function automatic pmt_dec_s decode(input logic [PMT_ADDR_W-1:0] a);
        pmt_dec_s d;
        d = '0;
        if (a == PMT_OFS_FLAG) begin
            d.hit = 1'b1;
            d.kind = 3'h3;
        end else if (a == PMT_OFS_ENABLE) begin
            d.hit = 1'b1;
            d.kind = 3'h4;
        end else begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                if (a == 8'(i) * PMT_INST_STRIDE + PMT_OFS_COUNT) begin
                    d = '{1'b1, 2'(i), 3'h0};
                end
                if (a == 8'(i) * PMT_INST_STRIDE + PMT_OFS_PERIOD) begin
                    d = '{1'b1, 2'(i), 3'h1};
                end
                if (a == 8'(i) * PMT_INST_STRIDE + PMT_OFS_CTRL) begin
                    d = '{1'b1, 2'(i), 3'h2};
                end
            end
        end
        return d;
    endfunction

    // One write strobe per register kind and timer
    function automatic logic wr_sel(input logic take, input pmt_dec_s dec,
        input logic [2:0] kind, input logic [1:0] inst);
        return take && dec.hit && dec.kind == kind && dec.inst == inst;
    endfunction

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0] count_reg [NUM_TIMERS];
    logic [7:0] period_reg [NUM_TIMERS];
    pmt_ctrl_s ctrl_reg [NUM_TIMERS];
    logic [PMT_PRE_W-1:0] pre_reg [NUM_TIMERS];
    logic [PMT_POST_W-1:0] post_reg [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] flag_reg;
    logic [NUM_TIMERS-1:0] enable_reg;
    logic [1:0] instr_div_reg;
    logic sleep_meta_reg;
    logic sleep_reg;
    logic spi_clk_reg;

    logic aw_full_reg;
    logic w_full_reg;
    logic [PMT_ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic w_byte0_reg;
    logic wr_fire;
    logic wr_take;
    logic wr_flag;
    logic wr_enable;
    pmt_dec_s wr_dec;
    pmt_dec_s rd_dec;
    logic [7:0] wbyte;

    logic instr_tick;
    logic [NUM_TIMERS-1:0] run;
    logic [NUM_TIMERS-1:0] pre_fire;
    logic [NUM_TIMERS-1:0] match_evt;
    logic [NUM_TIMERS-1:0] post_done;
    logic [NUM_TIMERS-1:0] flag_clr;
    logic [NUM_TIMERS-1:0] wr_count;
    logic [NUM_TIMERS-1:0] wr_period;
    logic [NUM_TIMERS-1:0] wr_ctrl;

    // ****************************************
    // AXI4-Lite write path
    // ****************************************
    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready = !w_full_reg;
    // Response waits for both halves and for the previous response to drain
    assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_take = wr_fire && w_byte0_reg;
    assign wr_dec = decode(aw_addr_reg);
    assign wbyte = w_data_reg[7:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= '0;
            w_byte0_reg <= 1'b0;
        end else if (s_axi_wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_byte0_reg <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PMT_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_dec.hit ? PMT_RESP_OKAY : PMT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Registers hold 8 bits, so only byte lane 0 carries a write
    always_comb begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            wr_count[i] = wr_sel(wr_take, wr_dec, 3'h0, 2'(i));
            wr_period[i] = wr_sel(wr_take, wr_dec, 3'h1, 2'(i));
            wr_ctrl[i] = wr_sel(wr_take, wr_dec, 3'h2, 2'(i));
        end
    end

    assign wr_flag = wr_sel(wr_take, wr_dec, 3'h3, 2'h0);
    assign wr_enable = wr_sel(wr_take, wr_dec, 3'h4, 2'h0);

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_dec = decode(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= PMT_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rd_dec.hit ? PMT_RESP_OKAY : PMT_RESP_SLVERR;
            s_axi_rdata <= '0;
            // Unmapped reads answer with zero data
            if (rd_dec.hit) begin
                unique case (rd_dec.kind)
                    3'h0: s_axi_rdata[7:0] <= count_reg[rd_dec.inst]; // [R11]
                    3'h1: s_axi_rdata[7:0] <= period_reg[rd_dec.inst]; // [R11]
                    3'h2: s_axi_rdata[7:0] <= {1'b0, ctrl_reg[rd_dec.inst][6:0]};
                    3'h3: s_axi_rdata[NUM_TIMERS-1:0] <= flag_reg;
                    3'h4: s_axi_rdata[NUM_TIMERS-1:0] <= enable_reg;
                    default: s_axi_rdata <= '0;
                endcase
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // Instruction clock and sleep
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_div_reg <= '0;
        end else begin
            instr_div_reg <= instr_div_reg + 2'h1;
        end
    end

    // Fixed divide by four; there is no other clock source
    assign instr_tick = instr_div_reg == 2'(PMT_SYS_PER_INSTR - 1); // [R01]

    // Sleep arrives from the core's power control, outside this clock's timing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_meta_reg <= 1'b0;
            sleep_reg <= 1'b0;
        end else begin
            sleep_meta_reg <= sleep_pin;
            sleep_reg <= sleep_meta_reg;
        end
    end

    // ****************************************
    // Timer datapath
    // ****************************************
    always_comb begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            run[i] = instr_tick && ctrl_reg[i].timer_on && !sleep_reg; // [R17] [R19]
            pre_fire[i] = run[i]
                && pre_reg[i] == pmt_pre_last(ctrl_reg[i].prescale_select); // [R03] [R04]
            match_evt[i] = pre_fire[i] && count_reg[i] == period_reg[i]; // [R06]
            post_done[i] = match_evt[i]
                && post_reg[i] == ctrl_reg[i].postscale_select; // [R08]
        end
    end

    // Software writes take priority over a coincident count step
    always_ff @(posedge aclk) begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            if (!aresetn) begin
                pre_reg[i] <= '0; // [R14]
            end else if (wr_count[i] || wr_ctrl[i]) begin
                pre_reg[i] <= '0; // [R13]
            end else if (pre_fire[i]) begin
                pre_reg[i] <= '0;
            end else if (run[i]) begin
                pre_reg[i] <= pre_reg[i] + 6'h01;
            end
        end
    end

    // A match zeroes the count in place of a step
    always_ff @(posedge aclk) begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            if (!aresetn) begin
                count_reg[i] <= PMT_COUNT_RST; // [R12]
            end else if (wr_count[i]) begin
                count_reg[i] <= wbyte; // [R11]
            end else if (pre_fire[i] && !wr_ctrl[i]) begin
                if (match_evt[i]) begin
                    count_reg[i] <= 8'h00; // [R07]
                end else begin
                    count_reg[i] <= count_reg[i] + 8'h01; // [R02] [R05]
                end
            end
        end
    end

    // Postscaler wraps to zero on the match that sets the flag
    always_ff @(posedge aclk) begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            if (!aresetn) begin
                post_reg[i] <= '0; // [R14]
            end else if (wr_count[i] || wr_ctrl[i]) begin
                post_reg[i] <= '0; // [R13]
            end else if (post_done[i]) begin
                post_reg[i] <= '0;
            end else if (match_evt[i]) begin
                post_reg[i] <= post_reg[i] + 4'h1; // [R07]
            end
        end
    end

    always_ff @(posedge aclk) begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            if (!aresetn) begin
                period_reg[i] <= PMT_PERIOD_RST; // [R12]
            end else if (wr_period[i]) begin
                period_reg[i] <= wbyte; // [R11]
            end
        end
    end

    // Bit 7 is unimplemented and always reads zero
    always_ff @(posedge aclk) begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            if (!aresetn) begin
                ctrl_reg[i] <= PMT_CTRL_RST;
            end else if (wr_ctrl[i]) begin
                ctrl_reg[i] <= {1'b0, wbyte[6:0]};
            end
        end
    end

    // ****************************************
    // Interrupt flags
    // ****************************************
    assign flag_clr = wr_flag ? wbyte[NUM_TIMERS-1:0] : '0;

    // A completion in the clearing cycle survives the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= (flag_reg & ~flag_clr) | post_done; // [R09]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_reg <= '0;
        end else if (wr_enable) begin
            enable_reg <= wbyte[NUM_TIMERS-1:0];
        end
    end

    assign irq = |(flag_reg & enable_reg); // [R10] [R18]

    // ****************************************
    // Match outputs
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_out <= '0;
        end else begin
            match_out <= match_evt; // [R15]
        end
    end

    // Halved match rate gives the serial port a square shift clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spi_clk_reg <= 1'b0;
        end else if (match_evt[0]) begin
            spi_clk_reg <= !spi_clk_reg; // [R16]
        end
    end

    assign spi_shift_clk = spi_clk_reg;

endmodule

// >>> pkg/pmt_pkg.sv
package pmt_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int PMT_NUM_DEF = 3;
    localparam int PMT_ADDR_W = 8;
    localparam int PMT_SYS_PER_INSTR = 4;
    localparam int PMT_PRE_W = 6;
    localparam int PMT_POST_W = 4;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] PMT_INST_STRIDE = 8'h10;
    localparam logic [7:0] PMT_OFS_COUNT = 8'h00;
    localparam logic [7:0] PMT_OFS_PERIOD = 8'h04;
    localparam logic [7:0] PMT_OFS_CTRL = 8'h08;
    localparam logic [7:0] PMT_OFS_FLAG = 8'h40;
    localparam logic [7:0] PMT_OFS_ENABLE = 8'h44;

    // ****************************************
    // Reset values and fields
    // ****************************************
    localparam logic [7:0] PMT_COUNT_RST = 8'h00;
    localparam logic [7:0] PMT_PERIOD_RST = 8'hFF;
    localparam logic [7:0] PMT_CTRL_RST = 8'h00;
    localparam int PMT_POST_LSB = 3;
    localparam int PMT_ON_BIT = 2;
    localparam int PMT_PRE_LSB = 0;
    localparam logic [5:0] PMT_PRE_LAST_1 = 6'h00;
    localparam logic [5:0] PMT_PRE_LAST_4 = 6'h03;
    localparam logic [5:0] PMT_PRE_LAST_16 = 6'h0F;
    localparam logic [5:0] PMT_PRE_LAST_64 = 6'h3F;
    localparam logic [1:0] PMT_RESP_OKAY = 2'h0;
    localparam logic [1:0] PMT_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic unused;
        logic [3:0] postscale_select;
        logic timer_on;
        logic [1:0] prescale_select;
    } pmt_ctrl_s;

    typedef struct packed {
        logic hit;
        logic [1:0] inst;
        logic [2:0] kind;
    } pmt_dec_s;

    function automatic logic [5:0] pmt_pre_last(input logic [1:0] sel);
        unique case (sel)
            2'h0: pmt_pre_last = PMT_PRE_LAST_1;
            2'h1: pmt_pre_last = PMT_PRE_LAST_4;
            2'h2: pmt_pre_last = PMT_PRE_LAST_16;
            2'h3: pmt_pre_last = PMT_PRE_LAST_64;
        endcase
    endfunction

endpackage

// >>> verification/pmt_timer_chk.sv
`timescale 1ns/1ns
module pmt_timer_chk #(
    parameter int NUM_TIMERS = 3
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    // Timer side
    input wire logic sleep_pin,
    input wire logic [NUM_TIMERS-1:0] match_out,
    input wire logic spi_shift_clk,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_arready_free: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready not the inverse of rvalid");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
        else $error("read answer without request");
    a_err_rdata: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |->
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
        else $error("bad read error answer");
    a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
        else $error("bad write response code");
    a_match_pulse: assert property (match_out != '0 |=> (match_out & $past(match_out)) == '0)
        else $error("match longer than one cycle");
    // Instruction tick is four clocks, so matches can never come closer
    a_match_tick: assert property (match_out[0] |=> !match_out[0] [*3])
        else $error("matches closer than one tick");
    a_spi_follow: assert property ($changed(spi_shift_clk) |-> match_out[0])
        else $error("shift clock moved without match");
    a_sleep_idle: assert property (sleep_pin [*8] |-> match_out == '0)
        else $error("timer ran while asleep");
    a_irq_clear: assert property ($fell(irq) |-> s_axi_bvalid)
        else $error("interrupt dropped without a write");
endmodule

bind pmt_timer pmt_timer_chk #(.NUM_TIMERS(NUM_TIMERS)) u_pmt_timer_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .sleep_pin(sleep_pin),
    .match_out(match_out), .spi_shift_clk(spi_shift_clk), .irq(irq)
);

// >>> verification/pmt_timer_tb_top.sv
`timescale 1ns/1ns
module pmt_timer_tb_top;
    import pmt_pkg::*;
    logic aclk;
    logic aresetn;
    logic [7:0] awaddr;
    logic [7:0] araddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] d;
    logic [31:0] d2;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [1:0] r;
    logic [2:0] match_out;
    logic awvalid, wvalid, bready, arvalid, rready, sleep_pin;
    logic awready, wready, bvalid, arready, rvalid, spi_shift_clk, irq;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    int n;

    pmt_timer #(.NUM_TIMERS(3)) u_pmt_timer (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sleep_pin(sleep_pin), .match_out(match_out), .spi_shift_clk(spi_shift_clk),
        .irq(irq)
    );

    // ****************************************
    // Clock, timeout, bus tasks
    // ****************************************
    initial begin
        aclk = 0;
        forever #4 aclk = ~aclk;
    end

    // Longest scenario is the 1:64 gap, under two thousand cycles in all
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end

    task finish_test;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1;
        wdata <= {24'h0, v};
        wvalid <= 1;
        bready <= 1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) break;
        end
        bready <= 0;
        r = bresp;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid) break;
        end
        rready <= 0;
        v = rdata;
        r = rresp;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a, d);
        chk(d, e);
    endtask

    // Cycles between two consecutive match pulses of one timer
    task gap(input int i);
        n = 0;
        do @(posedge aclk); while (match_out[i] !== 1'b1);
        d2 = 32'(spi_shift_clk);
        do begin
            @(posedge aclk);
            n++;
        end while (match_out[i] !== 1'b1);
    endtask

    function automatic logic [7:0] ctl(int post, int on, int pre);
        return 8'(post * 8 + on * 4 + pre);
    endfunction

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        aresetn = 0;
        {awvalid, wvalid, bready, arvalid, rready, sleep_pin} = '0;
        {awaddr, araddr, wdata} = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 3; i++) begin
            rchk(8'(i) * PMT_INST_STRIDE + PMT_OFS_COUNT, 32'h00);
            rchk(8'(i) * PMT_INST_STRIDE + PMT_OFS_PERIOD, 32'hFF);
            rchk(8'(i) * PMT_INST_STRIDE + PMT_OFS_CTRL, 32'h00);
        end
        wr(8'h10, 8'h5A);
        wr(8'h14, 8'hA5);
        rchk(8'h10, 32'h5A);
        rchk(8'h14, 32'hA5);
        rchk(PMT_OFS_PERIOD, 32'hFF);
        wr(8'h30, 8'h01);
        chk(r, PMT_RESP_SLVERR);
        rchk(8'h30, 32'h0);
        chk(r, PMT_RESP_SLVERR);
        wr(PMT_OFS_PERIOD, 8'h01);
        for (int s = 0; s < 4; s++) begin
            wr(PMT_OFS_CTRL, ctl(0, 1, s));
            gap(0);
            chk(n, 2 * 4 * (1 << (2 * s)));
            chk(spi_shift_clk, !d2[0]);
        end
        wr(8'h24, 8'h01);
        wr(8'h28, ctl(0, 1, 0));
        gap(2);
        chk(n, 8);
        wr(8'h28, ctl(0, 0, 0));
        wr(PMT_OFS_CTRL, ctl(0, 0, 0));
        rchk(PMT_OFS_FLAG, 32'h5);
        wr(PMT_OFS_FLAG, 8'h05);
        wr(PMT_OFS_ENABLE, 8'h01);
        chk(irq, 0);
        wr(PMT_OFS_CTRL, ctl(2, 1, 0));
        n = 0;
        do begin
            @(posedge aclk);
            if (match_out[0] === 1'b1) n++;
        end while (irq !== 1'b1);
        chk(n, 3);
        wr(PMT_OFS_ENABLE, 8'h00);
        chk(irq, 0);
        rchk(PMT_OFS_FLAG, 32'h1);
        wr(PMT_OFS_CTRL, ctl(0, 0, 0));
        wr(PMT_OFS_FLAG, 8'h01);
        rchk(PMT_OFS_FLAG, 32'h0);
        wr(PMT_OFS_COUNT, 8'h20);
        repeat (40) @(posedge aclk);
        rchk(PMT_OFS_COUNT, 32'h20);
        wr(PMT_OFS_PERIOD, 8'h80);
        wr(PMT_OFS_CTRL, ctl(0, 1, 0));
        sleep_pin <= 1;
        repeat (10) @(posedge aclk);
        rd(PMT_OFS_COUNT, d2);
        repeat (40) @(posedge aclk);
        rchk(PMT_OFS_COUNT, d2);
        rchk(PMT_OFS_PERIOD, 32'h80);
        sleep_pin <= 0;
        repeat (20) @(posedge aclk);
        // Mid-run reset while timer 0 is counting
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rchk(PMT_OFS_COUNT, 32'h00);
        rchk(PMT_OFS_PERIOD, 32'hFF);
        rchk(PMT_OFS_CTRL, 32'h00);
        finish_test();
    end
endmodule
